// ==== rotr_regs.sv ====
// Register group for identification, sequencer timing and manual control overrides.
// Behaviour
// - Upper identity bits 15:12 hold a fixed revision; writes are ignored.
// - Upper identity bits 11:0 hold the upper part code, read only.
// - Demodulator enables rx_chain_to_demod_delay times 5 us after the receive chain.
// - Receive chain starts only after filter calibration, 6.5 symbol periods.
// - Amplifier powers up amp_lead_time microseconds before transmit is enabled.
// - Switch goes high switch_lead_time microseconds before transmit is enabled.
// - Switch drops tx_end_switch_delay microseconds after the last chip.
// - Amplifier and modulator stop tx_end_amp_off_delay microseconds after the last chip.
// - Each effective line is generated value AND mask bit, then OR mask bit.
// - AND masks and OR masks sit in two registers, same bit per line.
// - AND 0xFFFE with OR 0x0000 forces front-end power-down low only.
// - AND 0xFFFF with OR 0x0001 forces front-end power-down high only.
// - Bit 15 overrides the active-low gain amplifier peak detector reset.
// - OR bit 14 forces global bias power-down; AND bit 14 gates it like every other AND bit.
// - Bit 13 overrides the external amplifier bias switch.
// - Bit 12 overrides buffer select: oscillator buffers at 0, amplifier at 1.
// - Bits 10 and 9 override amplifier halves; both down also downs mixers.
// - Bits 11,8,5,4,3,2,1,0 override the remaining block power-downs.
// - Bit 6 overrides the filter calibration oscillator power-down.
`timescale 1ns/1ps
`default_nettype none
module rotr_regs
  import rotr_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF,
  // Arbitrary identity values.
  parameter logic [3:0] REVISION = 4'h1,
  parameter logic [11:0] PART_UPPER = 12'h5a3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [5:0] regAddr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // Requests from the radio control logic.
  input wire logic rxOn,
  input wire logic txStart,
  input wire logic lastChip,
  input wire logic [15:0] genCtrl,
  // Sequenced enables.
  output logic rxChainEn,
  output logic demodEn,
  output logic ampOn,
  output logic switchOn,
  output logic txEnable,
  output logic modulatorEn,
  // Effective analog controls.
  output logic [15:0] ctrlEff,
  output logic upMixPowerdown
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    rotr_state_e state;
    logic [15:0] rdData;
    logic rdValid;
    logic [15:0] timing;
    logic [15:0] andM;
    logic [15:0] orM;
    logic chainEn;
    logic demod;
    logic amp;
    logic sw;
    logic tx;
    logic mod;
  } rotr_regs_s;

  localparam logic [15:0] CAL_LOAD = 16'(CAL_CYCLES - 1);

  rotr_regs_s r_reg;
  rotr_regs_s r_next;
  logic ldEn;
  logic [15:0] ldVal;
  logic [15:0] cnt;
  logic cntZero;
  logic [15:0] rxDelayC;
  logic [15:0] ampLeadC;
  logic [15:0] swLeadC;
  logic [15:0] endSwC;
  logic [15:0] endAmpC;
  logic [15:0] leadMaxC;
  logic [15:0] endMaxC;
  logic [15:0] genMix;

  rotr_ovr_if ovrBus ();

  // ==========================================================================
  // Phase timer and override stage
  // ==========================================================================
  rotr_countdown u_countdown (
    .clk(clk),
    .rst(rst),
    .load(ldEn),
    .loadValue(ldVal),
    .count(cnt),
    .zero(cntZero)
  );

  rotr_override u_override (
    .clk(clk),
    .rst(rst),
    .bus(ovrBus.ovr)
  );

  // Sequencer owns the switch and amplifier lines; the rest come from outside.
  always_comb begin
    genMix = genCtrl;
    genMix[BIT_SWITCH] = r_reg.sw;
    genMix[BIT_AMP_N] = ~r_reg.amp;
    genMix[BIT_AMP_P] = ~r_reg.amp;
  end

  assign ovrBus.genCtrl = genMix;
  assign ovrBus.andMask = r_reg.andM;
  assign ovrBus.orMask = r_reg.orM;

  // ==========================================================================
  // Time constants in cycles
  // ==========================================================================
  // Field values are turned into cycle counts at the 125 MHz clock.
  always_comb begin
    rxDelayC = rotrUsToCycles(6'(r_reg.timing[RXD_LSB +: 3] * RX_STEP_US));
    ampLeadC = rotrUsToCycles({3'h0, r_reg.timing[AMPL_LSB +: 3]});
    swLeadC = rotrUsToCycles({2'h0, r_reg.timing[SWL_LSB +: 4]});
    endSwC = rotrUsToCycles({3'h0, r_reg.timing[ENDSW_LSB +: 3]});
    endAmpC = rotrUsToCycles({3'h0, r_reg.timing[ENDAMP_LSB +: 3]});
    leadMaxC = rotrMax(ampLeadC, swLeadC);
    endMaxC = rotrMax(endSwC, endAmpC);
  end

  // ==========================================================================
  // Register access, sequencer and enables
  // ==========================================================================
  // Register writes, read decode, phase transitions and registered enables.
  always_comb begin
    r_next = r_reg;
    ldEn = 1'b0;
    ldVal = 16'h0000;
    r_next.rdValid = regRdEn;

    // Read decode; unmapped addresses read as zero.
    if (regRdEn) begin
      if (regAddr == ADDR_ID_UPPER) begin
        r_next.rdData = {REVISION, PART_UPPER};
      end else if (regAddr == ADDR_TIMING) begin
        r_next.rdData = r_reg.timing;
      end else if (regAddr == ADDR_AND_MASK) begin
        r_next.rdData = r_reg.andM;
      end else if (regAddr == ADDR_OR_MASK) begin
        r_next.rdData = r_reg.orM;
      end else begin
        r_next.rdData = 16'h0000;
      end
    end

    // Write decode; the identity word takes no writes.
    if (regWrEn) begin
      if (regAddr == ADDR_TIMING) begin
        r_next.timing = regWrData;
      end else if (regAddr == ADDR_AND_MASK) begin
        r_next.andM = regWrData;
      end else if (regAddr == ADDR_OR_MASK) begin
        r_next.orM = regWrData;
      end
    end

    // Phase sequencing.
    case (r_reg.state)
      ST_IDLE: begin
        if (txStart) begin
          r_next.state = ST_LEAD;
          ldEn = 1'b1;
          ldVal = rotrLoadOf(leadMaxC);
        end else if (rxOn) begin
          r_next.state = ST_CAL;
          ldEn = 1'b1;
          ldVal = CAL_LOAD;
        end
      end
      ST_CAL: begin
        if (!rxOn) begin
          r_next.state = ST_IDLE;
        end else if (cntZero) begin
          r_next.state = ST_CHAIN;
          ldEn = 1'b1;
          ldVal = rotrLoadOf(rxDelayC);
        end
      end
      ST_CHAIN: begin
        if (!rxOn) begin
          r_next.state = ST_IDLE;
        end else if (cntZero) begin
          r_next.state = ST_RX;
        end
      end
      ST_RX: begin
        if (txStart) begin
          r_next.state = ST_LEAD;
          ldEn = 1'b1;
          ldVal = rotrLoadOf(leadMaxC);
        end else if (!rxOn) begin
          r_next.state = ST_IDLE;
        end
      end
      ST_LEAD: begin
        if (cntZero) begin
          r_next.state = ST_TX;
        end
      end
      ST_TX: begin
        if (lastChip) begin
          r_next.state = ST_END;
          ldEn = 1'b1;
          ldVal = rotrLoadOf(endMaxC);
        end
      end
      ST_END: begin
        if (cntZero) begin
          r_next.state = ST_IDLE;
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase

    // Enables follow the current phase one cycle later.
    r_next.chainEn = (r_reg.state == ST_CHAIN) || (r_reg.state == ST_RX);
    r_next.demod = (r_reg.state == ST_RX);
    r_next.tx = (r_reg.state == ST_TX);
    r_next.amp = ((r_reg.state == ST_LEAD) && (cnt < ampLeadC))
      || (r_reg.state == ST_TX)
      || ((r_reg.state == ST_END) && ({1'b0, cnt} + {1'b0, endAmpC} >= {1'b0, endMaxC}));
    r_next.sw = ((r_reg.state == ST_LEAD) && (cnt < swLeadC))
      || (r_reg.state == ST_TX)
      || ((r_reg.state == ST_END) && ({1'b0, cnt} + {1'b0, endSwC} >= {1'b0, endMaxC}));
    r_next.mod = (r_reg.state == ST_TX)
      || ((r_reg.state == ST_END) && ({1'b0, cnt} + {1'b0, endAmpC} >= {1'b0, endMaxC}));
  end

  // State register; masks come out of reset passing every line unchanged.
  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.timing <= TIMING_RESET;
      r_reg.andM <= AND_RESET;
      r_reg.orM <= OR_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Every output is a flip-flop of this module or of the override stage.
  assign regRdData = r_reg.rdData;
  assign regRdValid = r_reg.rdValid;
  assign rxChainEn = r_reg.chainEn;
  assign demodEn = r_reg.demod;
  assign ampOn = r_reg.amp;
  assign switchOn = r_reg.sw;
  assign txEnable = r_reg.tx;
  assign modulatorEn = r_reg.mod;
  assign ctrlEff = ovrBus.effCtrl;
  assign upMixPowerdown = ovrBus.upMixPd;

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [15:0] calCnt;
  logic [15:0] chainCnt;

  // Cycle counters of the calibration and chain phases, for the checks only.
  always_ff @(posedge clk) begin
    if (rst || r_reg.state != ST_CAL) begin
      calCnt <= 16'h0000;
    end else begin
      calCnt <= calCnt + 16'h0001;
    end
    if (rst || r_reg.state != ST_CHAIN) begin
      chainCnt <= 16'h0000;
    end else begin
      chainCnt <= chainCnt + 16'h0001;
    end
  end

  chk_id_readonly: assert property (@(posedge clk) disable iff (rst)
    (regRdEn && regAddr == ADDR_ID_UPPER) |=> regRdData == {REVISION, PART_UPPER})
    else $error("Identity word read back wrong.");

  chk_timing_reset: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> r_reg.timing == TIMING_RESET)
    else $error("Time constants not at reset value.");

  chk_mask_reset: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> (r_reg.andM == AND_RESET) && (r_reg.orM == OR_RESET))
    else $error("Masks not at reset value.");

  chk_mask_write: assert property (@(posedge clk) disable iff (rst)
    (regWrEn && regAddr == ADDR_OR_MASK) |=> r_reg.orM == $past(regWrData))
    else $error("OR mask write lost.");

  chk_cal_wait: assert property (@(posedge clk) disable iff (rst)
    (r_reg.state == ST_CAL && r_next.state == ST_CHAIN) |-> calCnt == CAL_LOAD)
    else $error("Receive chain started before calibration time.");

  chk_demod_delay: assert property (@(posedge clk) disable iff (rst)
    (r_reg.state == ST_CHAIN && r_next.state == ST_RX) |-> chainCnt == rotrLoadOf(rxDelayC))
    else $error("Demodulator delay wrong.");

  chk_tx_leads: assert property (@(posedge clk) disable iff (rst)
    $rose(txEnable) |-> ampOn && (switchOn || swLeadC == 16'h0000))
    else $error("Transmit enabled before amplifier or switch.");

  chk_mod_with_amp: assert property (@(posedge clk) disable iff (rst)
    modulatorEn |-> ampOn)
    else $error("Modulator on while amplifier off.");

  chk_switch_off_end: assert property (@(posedge clk) disable iff (rst)
    (r_reg.state == ST_END && ({1'b0, cnt} + {1'b0, endSwC} < {1'b0, endMaxC})) |=> !switchOn)
    else $error("Switch still on after end delay.");

  chk_force_low: assert property (@(posedge clk) disable iff (rst)
    (r_reg.andM == 16'hfffe && r_reg.orM == 16'h0000) |=> !ctrlEff[0])
    else $error("Front-end power-down not forced low.");

  chk_force_high: assert property (@(posedge clk) disable iff (rst)
    (r_reg.andM == 16'hffff && r_reg.orM == 16'h0001) |=> ctrlEff[0])
    else $error("Front-end power-down not forced high.");

  chk_upmix_pd: assert property (@(posedge clk) disable iff (rst)
    (r_reg.orM[BIT_AMP_N] && r_reg.orM[BIT_AMP_P]) |=> upMixPowerdown)
    else $error("Up-conversion mixers not powered down.");

endmodule
`default_nettype wire

// ==== rotr_pkg.sv ====
// Shared constants, types and helpers for the radio override and timing register group.
package rotr_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam logic [15:0] US_CYCLES = 16'(US_NS / CLK_PERIOD_NS);
  localparam int RX_STEP_US = 5;
  localparam int SYMBOL_NS = 16000;
  localparam int CAL_HALF_SYMBOLS = 13;
  localparam int CAL_CYCLES_DEF = (CAL_HALF_SYMBOLS * SYMBOL_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

  // ==========================================================================
  // Register offsets, field positions and reset values
  // ==========================================================================
  localparam logic [5:0] ADDR_ID_UPPER = 6'h1f;
  localparam logic [5:0] ADDR_TIMING = 6'h20;
  localparam logic [5:0] ADDR_AND_MASK = 6'h21;
  localparam logic [5:0] ADDR_OR_MASK = 6'h22;
  localparam int RXD_LSB = 13;
  localparam int AMPL_LSB = 10;
  localparam int SWL_LSB = 6;
  localparam int ENDSW_LSB = 3;
  localparam int ENDAMP_LSB = 0;
  localparam logic [15:0] TIMING_RESET = 16'h7a94;
  localparam logic [15:0] AND_RESET = 16'hffff;
  localparam logic [15:0] OR_RESET = 16'h0000;
  localparam int BIT_SWITCH = 12;
  localparam int BIT_AMP_N = 10;
  localparam int BIT_AMP_P = 9;

  // ==========================================================================
  // Sequencer states, Gray coded along the usual path except ST_END to ST_IDLE
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CAL = 3'h1,
    ST_CHAIN = 3'h3,
    ST_RX = 3'h2,
    ST_LEAD = 3'h6,
    ST_TX = 3'h7,
    ST_END = 3'h5
  } rotr_state_e;

  // Converts a time in microseconds to clock cycles.
  function automatic logic [15:0] rotrUsToCycles(input logic [5:0] us);
    return 16'({10'h000, us} * US_CYCLES);
  endfunction

  // Counter load value that makes a phase last exactly the given cycles; zero cycles gives a one-cycle phase.
  function automatic logic [15:0] rotrLoadOf(input logic [15:0] cycles);
    return (cycles == 16'h0000) ? 16'h0000 : cycles - 16'h0001;
  endfunction

  // Larger of two cycle counts.
  function automatic logic [15:0] rotrMax(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction

endpackage

// ==== rotr_ovr_if.sv ====
// Interface carrying control values and masks into the override stage.
`timescale 1ns/1ps
`default_nettype none
interface rotr_ovr_if;
  logic [15:0] genCtrl;
  logic [15:0] andMask;
  logic [15:0] orMask;
  logic [15:0] effCtrl;
  logic upMixPd;

  // Override stage side.
  modport ovr (input genCtrl, input andMask, input orMask, output effCtrl, output upMixPd);
  // Register side.
  modport ctl (output genCtrl, output andMask, output orMask, input effCtrl, input upMixPd);
endinterface
`default_nettype wire

// ==== rotr_countdown.sv ====
// Loadable down counter that times the sequencer phases.
`timescale 1ns/1ps
`default_nettype none
module rotr_countdown
  import rotr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Load request.
  input wire logic load,
  input wire logic [15:0] loadValue,
  // Counter state.
  output logic [15:0] count,
  output logic zero
);

  typedef struct packed {
    logic [15:0] cnt;
  } rotr_cd_s;

  rotr_cd_s r_reg;
  rotr_cd_s r_next;

  // A load wins over counting; the counter rests at zero.
  always_comb begin
    r_next = r_reg;
    if (load) begin
      r_next.cnt = loadValue;
    end else if (r_reg.cnt != 16'h0000) begin
      r_next.cnt = r_reg.cnt - 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs.
  assign count = r_reg.cnt;
  assign zero = (r_reg.cnt == 16'h0000);

endmodule
`default_nettype wire

// ==== rotr_override.sv ====
// AND-then-OR manual override stage for the analog control lines.
`timescale 1ns/1ps
`default_nettype none
module rotr_override
  import rotr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control values and masks.
  rotr_ovr_if.ovr bus
);

  typedef struct packed {
    logic [15:0] eff;
    logic upMix;
  } rotr_ovr_s;

  rotr_ovr_s r_reg;
  rotr_ovr_s r_next;
  logic [15:0] used;

  // Each line is the generated value gated by its AND bit, then forced by its OR bit.
  for (genvar i = 0; i < 16; i++) begin : gen_bit
    assign used[i] = (bus.genCtrl[i] & bus.andMask[i]) | bus.orMask[i];
  end

  // Both amplifier halves down also powers down the up-conversion mixers.
  always_comb begin
    r_next = r_reg;
    r_next.eff = used;
    r_next.upMix = used[BIT_AMP_N] & used[BIT_AMP_P];
  end

  // State register; after reset every line and the mixer power-down sit at zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.effCtrl = r_reg.eff;
  assign bus.upMixPd = r_reg.upMix;

  chk_override_eff: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> bus.effCtrl == (($past(bus.genCtrl) & $past(bus.andMask)) | $past(bus.orMask)))
    else $error("Effective controls do not follow the masks.");

endmodule
`default_nettype wire

// ==== rotr_fe_model.sv ====
// Behavioural model of the analog front end that the effective control lines feed.
`timescale 1ns/1ps
`default_nettype none
module rotr_fe_model
  import rotr_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Effective controls.
  input wire logic [15:0] ctrlEff,
  input wire logic upMixPowerdown,
  // Observed analog state.
  output logic [15:0] feState,
  output logic mixerDown
);
  // Every analog block follows its own control line one edge later.
  always_ff @(posedge clk) begin
    feState <= ctrlEff;
    mixerDown <= upMixPowerdown;
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench for the radio override and timing register group.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rotr_pkg::*;
  // Identity values given to the design; both are arbitrary.
  localparam logic [3:0] REV = 4'h3;
  localparam logic [11:0] PART = 12'h6b1;
  localparam int CAL = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] regAddr = 6'h00;
  logic regWrEn = 1'b0;
  logic [15:0] regWrData = 16'h0000;
  logic regRdEn = 1'b0;
  logic [15:0] regRdData;
  logic regRdValid;
  logic rxOn = 1'b0;
  logic txStart = 1'b0;
  logic lastChip = 1'b0;
  logic [15:0] genCtrl = 16'h0000;
  logic rxChainEn, demodEn, ampOn, switchOn, txEnable, modulatorEn, upMixPowerdown, mixerDown;
  logic [15:0] ctrlEff, feState;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;

  // Clock at 125 MHz and a free cycle counter for timing figures.
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  rotr_regs #(.CAL_CYCLES(CAL), .REVISION(REV), .PART_UPPER(PART)) dut_u (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid), .rxOn(rxOn),
    .txStart(txStart), .lastChip(lastChip), .genCtrl(genCtrl), .rxChainEn(rxChainEn),
    .demodEn(demodEn), .ampOn(ampOn), .switchOn(switchOn), .txEnable(txEnable),
    .modulatorEn(modulatorEn), .ctrlEff(ctrlEff), .upMixPowerdown(upMixPowerdown));

  rotr_fe_model fe_u (.clk(clk), .ctrlEff(ctrlEff), .upMixPowerdown(upMixPowerdown),
    .feState(feState), .mixerDown(mixerDown));

  // Prints the verdict and ends the run.
  task automatic close_out;
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t value mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Writes one register word.
  task automatic regWrite(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask

  // Reads one register word and compares it.
  task automatic regRead(input logic [5:0] a, input logic [15:0] exp);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    check(16'(regRdValid), 16'h0001);
    check(regRdData, exp);
  endtask

  // Waits, bounded, until a chosen sequencer output reaches a level.
  task automatic waitLvl(input int sel, input logic lvl);
    logic v;
    for (int i = 0; i < 4000; i++) begin
      case (sel)
        0: v = rxChainEn;
        1: v = demodEn;
        2: v = ampOn;
        3: v = switchOn;
        default: v = txEnable;
      endcase
      if (v === lvl) return;
      @(negedge clk);
    end
    err_total++;
    $display("[FAIL] %0t wait for output %0d ran out", $time, sel);
    close_out();
  endtask

  // Reset values, read-only identity and an unmapped place.
  task automatic t_regs;
    regRead(ADDR_ID_UPPER, {REV, PART});
    regRead(ADDR_TIMING, 16'h7a94);
    regRead(ADDR_AND_MASK, 16'hffff);
    regRead(ADDR_OR_MASK, 16'h0000);
    regWrite(ADDR_ID_UPPER, 16'hffff);
    regRead(ADDR_ID_UPPER, {REV, PART});
    regRead(6'h23, 16'h0000);
  endtask

  // Forces every line low by the AND mask, then high by the OR mask.
  task automatic t_override;
    logic [15:0] a, o, e;
    for (int i = 0; i < 32; i++) begin
      a = (i < 16) ? ~(16'h0001 << i) : 16'hffff;
      o = (i < 16) ? 16'h0000 : (16'h0001 << (i - 16));
      genCtrl = (i < 16) ? 16'hffff : 16'h0000;
      regWrite(ADDR_AND_MASK, a);
      regWrite(ADDR_OR_MASK, o);
      // Idle sequencer supplies switch low and both amplifier halves down.
      e = ((((genCtrl & 16'he9ff) | 16'h0600) & a) | o);
      repeat (3) @(negedge clk);
      check(ctrlEff, e);
      check(feState, e);
      check(16'(mixerDown), 16'(e[10] & e[9]));
      regRead(ADDR_AND_MASK, a);
    end
    // Both amplifier halves forced down through the OR mask take the mixers down.
    regWrite(ADDR_AND_MASK, 16'hf9ff);
    regWrite(ADDR_OR_MASK, 16'h0600);
    repeat (3) @(negedge clk);
    check(ctrlEff, 16'h0600);
    check(16'(mixerDown), 16'h0001);
    regWrite(ADDR_AND_MASK, 16'hffff);
    regWrite(ADDR_OR_MASK, 16'h0000);
  endtask

  // Receive start-up, a transmit taken from receive, then a chain phase aborted by dropping rxOn.
  task automatic t_rx;
    int t0, t1;
    @(negedge clk);
    rxOn = 1'b1;
    t0 = cyc;
    waitLvl(0, 1'b1);
    t1 = cyc;
    check(16'((t1 - t0 >= CAL) && (t1 - t0 <= CAL + 3)), 16'h0001);
    waitLvl(1, 1'b1);
    check(16'(cyc - t1), 16'h0753);
    // Transmit request while receiving; default leads give a 1250 cycle lead phase.
    txStart = 1'b1;
    t1 = cyc;
    @(negedge clk);
    txStart = 1'b0;
    repeat (2) @(negedge clk);
    check(16'({rxChainEn, demodEn}), 16'h0000);
    waitLvl(4, 1'b1);
    check(16'(cyc - t1), 16'h04e4);
    lastChip = 1'b1;
    @(negedge clk);
    lastChip = 1'b0;
    waitLvl(2, 1'b0);
    check(16'({switchOn, modulatorEn}), 16'h0000);
    // rxOn still high restarts reception; dropping it aborts the chain phase.
    waitLvl(0, 1'b1);
    rxOn = 1'b0;
    repeat (3) @(negedge clk);
    check(16'({rxChainEn, demodEn}), 16'h0000);
  endtask

  // Transmit with short leads and tails.
  task automatic t_tx;
    int tSw, tAmp, tEnd;
    regWrite(ADDR_TIMING, 16'h28ca);
    @(negedge clk);
    txStart = 1'b1;
    @(negedge clk);
    txStart = 1'b0;
    waitLvl(3, 1'b1);
    tSw = cyc;
    waitLvl(2, 1'b1);
    tAmp = cyc;
    waitLvl(4, 1'b1);
    check(16'(cyc - tSw), 16'h0177);
    check(16'(cyc - tAmp), 16'h00fa);
    lastChip = 1'b1;
    tEnd = cyc;
    @(negedge clk);
    lastChip = 1'b0;
    waitLvl(3, 1'b0);
    tSw = cyc;
    check(16'((tSw - tEnd >= 125) && (tSw - tEnd <= 128)), 16'h0001);
    check(16'({ampOn, modulatorEn}), 16'h0003);
    waitLvl(2, 1'b0);
    check(16'(cyc - tSw), 16'h007d);
    check(16'(modulatorEn), 16'h0000);
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_override();
    t_rx();
    t_tx();
    close_out();
  end
endmodule
`default_nettype wire
